// ---- hw/tmr_params.svh ----
// timer block constants: offsets, field positions, reset values
`ifndef TMR_PARAMS_SVH
`define TMR_PARAMS_SVH
`define TMR_OFF_CTRL    8'h00
`define TMR_OFF_CNT_HI  8'h04
`define TMR_OFF_CNT_LO  8'h08
`define TMR_OFF_RELOAD  8'h0c
`define TMR_OFF_PWM     8'h10
`define TMR_OFF_STATUS  8'h14
`define TMR_OFF_MASK    8'h18
`define TMR_CTRL_EN     0
`define TMR_CTRL_MODE_L 1
`define TMR_CTRL_MODE_H 3
`define TMR_CTRL_POL    4
`define TMR_CTRL_ALT    5
`define TMR_CTRL_DLY_L  8
`define TMR_CTRL_DLY_H  15
`define TMR_ST_RELOAD   0
`define TMR_ST_CAPTURE  1
`define TMR_ST_GATE     2
`define TMR_RST_CTRL    16'h0000
`define TMR_RST_RELOAD  16'hffff
`define TMR_RST_PWM     16'h0000
`define TMR_COUNT_ONE   16'h0001
`endif

// ---- hw/tmr_pkg.sv ----
// timer types and shared helpers
package tmr_pkg;
  typedef enum logic [2:0] {
    TMR_CONT, TMR_GATED, TMR_CAPCMP, TMR_PWM2, TMR_CAPRST, TMR_CMPCNT
  } tmr_mode_t;
  typedef enum logic [1:0] {PEND_NONE, PEND_OUT, PEND_OUTN} tmr_pend_t;
  // polarity 0 picks rising, 1 picks falling
  function automatic logic sel_edge(input logic pol, input logic rise,
                                    input logic fall);
    sel_edge = pol ? fall : rise;
  endfunction
endpackage

// ---- hw/tmr_out_if.sv ----
// link between timer core and its output stage
`timescale 1ns/1ps
`default_nettype none
interface tmr_out_if;
  logic       en;
  logic       pwm_mode;
  logic       pol;
  logic       match;
  logic       reload;
  logic [7:0] delay;
  logic       out;
  logic       out_n;
  modport core (output en, pwm_mode, pol, match, reload, delay,
                input out, out_n);
  modport drv  (input en, pwm_mode, pol, match, reload, delay,
                output out, out_n);
endinterface
`default_nettype wire

// ---- hw/tmr_sync.sv ----
// three-stage input synchroniser with agreement filter and edges
`timescale 1ns/1ps
`default_nettype none
module tmr_sync (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic din,
  output var  logic lvl,
  output var  logic rise,
  output var  logic fall
);
  logic s1_r, s2_r, s3_r, lvl_r, rise_r, fall_r;
  logic lvl_nxt, rise_nxt, fall_nxt;
  always_comb begin
    lvl_nxt  = (s2_r == s3_r) ? s3_r : lvl_r;
    rise_nxt = lvl_nxt & ~lvl_r;
    fall_nxt = ~lvl_nxt & lvl_r;
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {s1_r, s2_r, s3_r, lvl_r, rise_r, fall_r} <= 6'h00;
    end else begin
      s1_r   <= din;
      s2_r   <= s1_r;
      s3_r   <= s2_r;
      lvl_r  <= lvl_nxt;
      rise_r <= rise_nxt;
      fall_r <= fall_nxt;
    end
  end
  assign lvl  = lvl_r;
  assign rise = rise_r;
  assign fall = fall_r;
endmodule
`default_nettype wire

// ---- hw/tmr_out.sv ----
// timer output pair: toggle mode and dual pwm with assert delay
`timescale 1ns/1ps
`default_nettype none
module tmr_out (
  input  wire logic clk,
  input  wire logic rst_n,
  tmr_out_if.drv    io
);
  logic                 out_r, outn_r, out_nxt, outn_nxt;
  logic [7:0]           dcnt_r, dcnt_nxt;
  tmr_pkg::tmr_pend_t   pend_r, pend_nxt;
  always_comb begin
    out_nxt  = out_r;
    outn_nxt = outn_r;
    pend_nxt = pend_r;
    dcnt_nxt = dcnt_r;
    if (!io.en) begin
      out_nxt  = io.pol;
      outn_nxt = ~io.pol;
      pend_nxt = tmr_pkg::PEND_NONE;
    end else if (!io.pwm_mode) begin
      // toggles from own state, so a polarity write is not seen here
      if (io.reload) begin
        out_nxt  = ~out_r;
        outn_nxt = out_r;
      end
    end else begin
      case (pend_r)
        tmr_pkg::PEND_OUT: begin
          if (dcnt_r == 8'h00) begin
            out_nxt  = ~io.pol;
            pend_nxt = tmr_pkg::PEND_NONE;
          end else begin
            dcnt_nxt = dcnt_r - 8'h01;
          end
        end
        tmr_pkg::PEND_OUTN: begin
          if (dcnt_r == 8'h00) begin
            outn_nxt = ~io.pol;
            pend_nxt = tmr_pkg::PEND_NONE;
          end else begin
            dcnt_nxt = dcnt_r - 8'h01;
          end
        end
        default: pend_nxt = tmr_pkg::PEND_NONE;
      endcase
      // deassertion is immediate, assertion waits out the dead time
      if (io.match) begin
        outn_nxt = io.pol;
        if (io.delay == 8'h00) begin
          out_nxt  = ~io.pol;
          pend_nxt = tmr_pkg::PEND_NONE;
        end else begin
          pend_nxt = tmr_pkg::PEND_OUT;
          dcnt_nxt = io.delay - 8'h01;
        end
      end
      if (io.reload) begin
        out_nxt = io.pol;
        if (io.delay == 8'h00) begin
          outn_nxt = ~io.pol;
          pend_nxt = tmr_pkg::PEND_NONE;
        end else begin
          pend_nxt = tmr_pkg::PEND_OUTN;
          dcnt_nxt = io.delay - 8'h01;
        end
      end
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_r  <= 1'b0;
      outn_r <= 1'b1;
      pend_r <= tmr_pkg::PEND_NONE;
      dcnt_r <= 8'h00;
    end else begin
      out_r  <= out_nxt;
      outn_r <= outn_nxt;
      pend_r <= pend_nxt;
      dcnt_r <= dcnt_nxt;
    end
  end
  assign io.out   = out_r;
  assign io.out_n = outn_r;
endmodule
`default_nettype wire

// ---- hw/tmr_top.sv ----
// 16-bit timer with coherent count readback, apb registers and pins
//
// Added by the designer: the register offsets and the APB slave port.
`include "tmr_params.svh"
`timescale 1ns/1ps
`default_nettype none
module tmr_top (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  input  wire logic        timer_input,
  input  wire logic        comparator_out,
  output var  logic        timer_output_pin,
  output var  logic        timer_output_pin_n,
  output var  logic        timer_output_pin_oe,
  output var  logic        irq
);

  // control and data registers
  logic [15:0] timer_control_zero_r, ctrl_nxt;
  logic [15:0] count_r, count_nxt;
  logic [15:0] reload_r, reload_nxt;
  logic [15:0] pwm_r, pwm_nxt;
  logic [7:0]  hold_r, hold_nxt;
  logic        latched_r, latched_nxt;
  logic        started_r, started_nxt;
  logic [2:0]  status_r, status_nxt;
  logic [2:0]  mask_r, mask_nxt;
  logic        irq_r, irq_nxt;
  logic        oe_r, oe_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic        pready_r, pready_nxt;
  logic        pslverr_r, pslverr_nxt;

  // decoded control
  logic                en;
  logic                pol;
  tmr_pkg::tmr_mode_t  mode;
  logic [7:0]          delay;

  // synchronised inputs
  logic tin_lvl, tin_rise, tin_fall;
  logic cmp_lvl, cmp_rise, cmp_fall;
  logic tin_sel, cmp_sel;

  // timer events
  logic go, restart, reload_ev, match_ev;
  logic ev_cap, ev_gate;

  // bus strobes
  logic rd_take, wr_take, hit;

  tmr_out_if oif ();

  assign en    = timer_control_zero_r[`TMR_CTRL_EN];
  assign pol   = timer_control_zero_r[`TMR_CTRL_POL];
  assign mode  = tmr_pkg::tmr_mode_t'(
                   timer_control_zero_r[`TMR_CTRL_MODE_H:`TMR_CTRL_MODE_L]);
  assign delay = timer_control_zero_r[`TMR_CTRL_DLY_H:`TMR_CTRL_DLY_L];

  tmr_sync u_tin_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .din   (timer_input),
    .lvl   (tin_lvl),
    .rise  (tin_rise),
    .fall  (tin_fall)
  );

  tmr_sync u_cmp_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .din   (comparator_out),
    .lvl   (cmp_lvl),
    .rise  (cmp_rise),
    .fall  (cmp_fall)
  );

  assign tin_sel = tmr_pkg::sel_edge(pol, tin_rise, tin_fall);
  assign cmp_sel = tmr_pkg::sel_edge(pol, cmp_rise, cmp_fall);

  assign oif.en       = en;
  assign oif.pwm_mode = (mode == tmr_pkg::TMR_PWM2);
  assign oif.pol      = pol;
  assign oif.match    = match_ev;
  assign oif.reload   = reload_ev;
  assign oif.delay    = delay;

  tmr_out u_out (
    .clk   (clk),
    .rst_n (rst_n),
    .io    (oif)
  );

  // apb: read data is sampled on the first access edge, the transfer
  // completes one cycle later; writes land on the completing edge
  assign rd_take = psel & penable & ~pready_r & ~pwrite;
  assign wr_take = psel & penable & pready_r & pwrite;
  assign hit     = (paddr == `TMR_OFF_CTRL)   ||
                   (paddr == `TMR_OFF_CNT_HI) ||
                   (paddr == `TMR_OFF_CNT_LO) ||
                   (paddr == `TMR_OFF_RELOAD) ||
                   (paddr == `TMR_OFF_PWM)    ||
                   (paddr == `TMR_OFF_STATUS) ||
                   (paddr == `TMR_OFF_MASK);

  always_comb begin
    pready_nxt  = psel & penable & ~pready_r;
    pslverr_nxt = psel & penable & ~pready_r & ~hit;
    prdata_nxt  = prdata_r;
    if (rd_take) begin
      prdata_nxt = 32'h0000_0000;
      if (paddr == `TMR_OFF_CTRL) begin
        prdata_nxt[15:0] = timer_control_zero_r;
      end else if (paddr == `TMR_OFF_CNT_HI) begin
        prdata_nxt[7:0] = count_r[15:8];
      end else if (paddr == `TMR_OFF_CNT_LO) begin
        if (en && latched_r) begin
          prdata_nxt[7:0] = hold_r;
        end else begin
          prdata_nxt[7:0] = count_r[7:0];
        end
      end else if (paddr == `TMR_OFF_RELOAD) begin
        prdata_nxt[15:0] = reload_r;
      end else if (paddr == `TMR_OFF_PWM) begin
        prdata_nxt[15:0] = pwm_r;
      end else if (paddr == `TMR_OFF_STATUS) begin
        prdata_nxt[2:0] = status_r;
      end else if (paddr == `TMR_OFF_MASK) begin
        prdata_nxt[2:0] = mask_r;
      end
    end
  end

  // readback holding register; touches nothing the counter uses
  always_comb begin
    hold_nxt    = hold_r;
    latched_nxt = latched_r;
    if (rd_take && paddr == `TMR_OFF_CNT_HI && en) begin
      hold_nxt    = count_r[7:0];
      latched_nxt = 1'b1;
    end else if (rd_take && paddr == `TMR_OFF_CNT_LO) begin
      latched_nxt = 1'b0;
    end
  end

  // counter core
  always_comb begin
    count_nxt   = count_r;
    pwm_nxt     = pwm_r;
    started_nxt = started_r;
    go          = 1'b0;
    restart     = 1'b0;
    reload_ev   = 1'b0;
    match_ev    = 1'b0;
    ev_cap      = 1'b0;
    ev_gate     = 1'b0;
    if (!en) begin
      started_nxt = 1'b0;
    end else begin
      case (mode)
        tmr_pkg::TMR_GATED: begin
          go      = (tin_lvl != pol);
          ev_gate = pol ? tin_rise : tin_fall;
        end
        tmr_pkg::TMR_CAPCMP: begin
          if (!started_r) begin
            // the starting edge raises no event
            started_nxt = tin_sel;
          end else begin
            go = 1'b1;
            if (tin_sel) begin
              pwm_nxt = count_r;
              ev_cap  = 1'b1;
            end
          end
        end
        tmr_pkg::TMR_CAPRST: begin
          go = 1'b1;
          if (tin_sel) begin
            pwm_nxt = count_r;
            ev_cap  = 1'b1;
            restart = 1'b1;
          end
        end
        tmr_pkg::TMR_CMPCNT: begin
          go = 1'b1;
          if (cmp_sel) begin
            pwm_nxt = count_r;
            ev_cap  = 1'b1;
          end
        end
        default: go = 1'b1;
      endcase
      if (restart) begin
        count_nxt = `TMR_COUNT_ONE;
      end else if (go) begin
        if (count_r == reload_r) begin
          count_nxt = `TMR_COUNT_ONE;
          reload_ev = 1'b1;
        end else begin
          count_nxt = count_r + 16'h0001;
        end
      end
      match_ev = go && (mode == tmr_pkg::TMR_PWM2) &&
                 (count_r == pwm_r) && !reload_ev;
    end
    // software writes land last and override the counter step
    if (wr_take && paddr == `TMR_OFF_CNT_HI) begin
      count_nxt[15:8] = pwdata[7:0];
    end
    if (wr_take && paddr == `TMR_OFF_CNT_LO) begin
      count_nxt[7:0] = pwdata[7:0];
    end
    if (wr_take && paddr == `TMR_OFF_PWM) begin
      pwm_nxt = pwdata[15:0];
    end
  end

  // configuration, sticky status, interrupt and pin enable
  always_comb begin
    ctrl_nxt   = timer_control_zero_r;
    reload_nxt = reload_r;
    mask_nxt   = mask_r;
    status_nxt = status_r;
    if (wr_take && paddr == `TMR_OFF_CTRL) begin
      ctrl_nxt = pwdata[15:0];
    end
    if (wr_take && paddr == `TMR_OFF_RELOAD) begin
      reload_nxt = pwdata[15:0];
    end
    if (wr_take && paddr == `TMR_OFF_MASK) begin
      mask_nxt = pwdata[2:0];
    end
    if (wr_take && paddr == `TMR_OFF_STATUS) begin
      status_nxt = status_r & ~pwdata[2:0];
    end
    // a new event beats a simultaneous clear
    status_nxt[`TMR_ST_RELOAD]  = status_nxt[`TMR_ST_RELOAD]  | reload_ev;
    status_nxt[`TMR_ST_CAPTURE] = status_nxt[`TMR_ST_CAPTURE] | ev_cap;
    status_nxt[`TMR_ST_GATE]    = status_nxt[`TMR_ST_GATE]    | ev_gate;
    irq_nxt = |(status_nxt & mask_nxt);
    oe_nxt  = ctrl_nxt[`TMR_CTRL_ALT];
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      timer_control_zero_r <= `TMR_RST_CTRL;
      count_r              <= 16'h0000;
      reload_r             <= `TMR_RST_RELOAD;
      pwm_r                <= `TMR_RST_PWM;
      hold_r               <= 8'h00;
      latched_r            <= 1'b0;
      started_r            <= 1'b0;
      status_r             <= 3'h0;
      mask_r               <= 3'h0;
      irq_r                <= 1'b0;
      oe_r                 <= 1'b0;
      prdata_r             <= 32'h0000_0000;
      pready_r             <= 1'b0;
      pslverr_r            <= 1'b0;
    end else begin
      timer_control_zero_r <= ctrl_nxt;
      count_r              <= count_nxt;
      reload_r             <= reload_nxt;
      pwm_r                <= pwm_nxt;
      hold_r               <= hold_nxt;
      latched_r            <= latched_nxt;
      started_r            <= started_nxt;
      status_r             <= status_nxt;
      mask_r               <= mask_nxt;
      irq_r                <= irq_nxt;
      oe_r                 <= oe_nxt;
      prdata_r             <= prdata_nxt;
      pready_r             <= pready_nxt;
      pslverr_r            <= pslverr_nxt;
    end
  end

  assign prdata              = prdata_r;
  assign pready              = pready_r;
  assign pslverr             = pslverr_r;
  assign irq                 = irq_r;
  assign timer_output_pin    = oif.out;
  assign timer_output_pin_n  = oif.out_n;
  assign timer_output_pin_oe = oe_r;

endmodule
`default_nettype wire

// ---- bench/tmr_far.sv ----
// far-side model: drives the timer input and comparator lines
`timescale 1ns/1ps
`default_nettype none
module tmr_far (
  input  wire logic clk,
  output var  logic tin,
  output var  logic cmp
);
  initial begin
    tin = 1'b0;
    cmp = 1'b0;
  end
  // each level is held long enough to clear the input filter
  task automatic drive(input logic sel, input logic v);
    if (sel)
      cmp <= v;
    else
      tin <= v;
    repeat (10) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// ---- bench/tmr_chk_sva.sv ----
// assertion checker on the timer's top-level ports
`timescale 1ns/1ps
`default_nettype none
module tmr_chk (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        timer_input,
  input wire logic        comparator_out,
  input wire logic        timer_output_pin,
  input wire logic        timer_output_pin_n,
  input wire logic        timer_output_pin_oe,
  input wire logic        irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic ctl_wr;
  assign ctl_wr = psel && penable && pready && pwrite && paddr == 8'h00;
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  a_ready_in_access: assert property (pready |-> psel && penable)
    else $error("pready outside an access phase");
  a_access_two: assert property (psel && penable && !pready |=> pready)
    else $error("access phase not two cycles");
  a_err_unmapped: assert property (pready && paddr > 8'h18 |-> pslverr)
    else $error("unmapped access without error");
  a_err_mapped: assert property (
    pready && paddr <= 8'h18 && paddr[1:0] == 2'b00 |-> !pslverr)
    else $error("error on a mapped register");
  a_err_zero: assert property (pready && pslverr && !pwrite |-> prdata == 0)
    else $error("unmapped read data not zero");
  a_rdata_holds: assert property (
    !(psel && penable && !pready && !pwrite) |=> $stable(prdata))
    else $error("read data moved outside a read");
  a_oe_follows: assert property (
    ctl_wr |-> ##2 timer_output_pin_oe == $past(pwdata[5], 2))
    else $error("pin enable not following select bit");
  a_idle_pin_pol: assert property (
    ctl_wr && !pwdata[0] |-> ##2 timer_output_pin == $past(pwdata[4], 2)
    && timer_output_pin_n == !$past(pwdata[4], 2))
    else $error("idle pin level differs from polarity");
endmodule
bind tmr_top tmr_chk chk_u (.clk(clk), .rst_n(rst_n), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .timer_input(timer_input), .comparator_out(comparator_out),
  .timer_output_pin(timer_output_pin),
  .timer_output_pin_n(timer_output_pin_n),
  .timer_output_pin_oe(timer_output_pin_oe), .irq(irq));
`default_nettype wire

// ---- bench/testbench.sv ----
// self-checking bench for the timer: apb traffic, pins and input lines
`include "tmr_params.svh"
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        clk;
  logic        rst_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        tin;
  logic        cmp;
  logic        pin;
  logic        pin_n;
  logic        pin_oe;
  logic        irq;
  logic [31:0] rd;
  logic        er;
  logic [15:0] v1;
  logic [15:0] v2;
  logic [2:0]  m;
  logic        p;
  logic        s;
  logic [7:0]  d;
  int          w;
  int          n_mismatch;
  int          check_count;
  logic [2:0]  cm [3] = '{tmr_pkg::TMR_CAPCMP, tmr_pkg::TMR_CAPRST,
                          tmr_pkg::TMR_CMPCNT};
  tmr_top dut_u (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .timer_input(tin),
    .comparator_out(cmp), .timer_output_pin(pin),
    .timer_output_pin_n(pin_n), .timer_output_pin_oe(pin_oe), .irq(irq));
  tmr_far far_u (.clk(clk), .tin(tin), .cmp(cmp));
  always #20 clk = ~clk;
  task automatic test_done();
    $display("mismatches %0d of %0d checks", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] dat);
    int n;
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= dat;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: no bus answer", $time);
      test_done();
    end
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // one idle edge, so a following call never re-drives psel in one step
    @(posedge clk);
  endtask
  function automatic logic [31:0] ctl(input logic [2:0] md, input logic pl,
                                      input logic en, input logic [7:0] dl);
    ctl = {16'h0, dl, 2'b00, 1'b1, pl, md, en};
  endfunction
  // cycles the output pin stays high, from its next rising edge
  task automatic high_width(output int cyc);
    int n;
    n = 0;
    cyc = 0;
    while (pin !== 1'b0 && n < 300) begin
      @(posedge clk);
      n++;
    end
    while (pin !== 1'b1 && n < 300) begin
      @(posedge clk);
      n++;
    end
    while (pin === 1'b1 && n < 300) begin
      @(posedge clk);
      n++;
      cyc++;
    end
    if (n >= 300) begin
      n_mismatch++;
      test_done();
    end
  endtask
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    n_mismatch = 0;
    check_count = 0;
    tick(10);
    rst_n <= 1'b1;
    tick(1);
    apb(0, `TMR_OFF_RELOAD, 0);
    chk(rd, 32'h0000ffff);
    apb(0, 8'h1c, 0);
    chk({rd[30:0], er}, 32'h1);
    apb(1, `TMR_OFF_CNT_HI, 32'h00);
    apb(1, `TMR_OFF_CNT_LO, 32'hf0);
    apb(1, `TMR_OFF_CTRL, ctl(tmr_pkg::TMR_CONT, 1'b0, 1'b1, 8'h00));
    apb(0, `TMR_OFF_CNT_HI, 0);
    v1[15:8] = rd[7:0];
    tick(10);
    apb(0, `TMR_OFF_CNT_LO, 0);
    v1[7:0] = rd[7:0];
    apb(0, `TMR_OFF_CNT_HI, 0);
    v2[15:8] = rd[7:0];
    apb(0, `TMR_OFF_CNT_LO, 0);
    v2[7:0] = rd[7:0];
    chk(v2 - v1, 16'd18);
    apb(1, `TMR_OFF_CTRL, ctl(tmr_pkg::TMR_CONT, 1'b1, 1'b1, 8'h00));
    tick(2);
    chk(pin, 1'b0);
    apb(1, `TMR_OFF_CTRL, 32'h0);
    apb(0, `TMR_OFF_CNT_HI, 0);
    apb(1, `TMR_OFF_CNT_LO, 32'h5a);
    apb(0, `TMR_OFF_CNT_LO, 0);
    chk(rd, 32'h5a);
    apb(1, `TMR_OFF_RELOAD, 32'h10);
    apb(1, `TMR_OFF_CNT_HI, 32'h00);
    apb(1, `TMR_OFF_CNT_LO, 32'h01);
    apb(1, `TMR_OFF_MASK, 32'h1);
    apb(1, `TMR_OFF_CTRL, ctl(tmr_pkg::TMR_CONT, 1'b0, 1'b1, 8'h00));
    high_width(w);
    chk(w, 16);
    chk(irq, 1'b1);
    apb(1, `TMR_OFF_MASK, 32'h0);
    tick(2);
    chk(irq, 1'b0);
    for (int i = 0; i < 2; i++) begin
      p = i[0];
      far_u.drive(1'b0, p);
      // gate closed before clearing, so the cleared count cannot creep
      apb(1, `TMR_OFF_CTRL, ctl(tmr_pkg::TMR_GATED, p, 1'b1, 8'h00));
      apb(1, `TMR_OFF_CNT_LO, 32'h0);
      apb(1, `TMR_OFF_STATUS, 32'h7);
      tick(20);
      apb(1, `TMR_OFF_CTRL, ctl(tmr_pkg::TMR_GATED, p, 1'b0, 8'h00));
      apb(0, `TMR_OFF_CNT_LO, 0);
      chk(rd, 32'h0);
      far_u.drive(1'b0, !p);
      apb(1, `TMR_OFF_CTRL, ctl(tmr_pkg::TMR_GATED, p, 1'b1, 8'h00));
      far_u.drive(1'b0, p);
      apb(0, `TMR_OFF_STATUS, 0);
      chk(rd[`TMR_ST_GATE], 1'b1);
      apb(1, `TMR_OFF_CTRL, 32'h0);
      apb(0, `TMR_OFF_CNT_LO, 0);
      chk(rd == 0, 1'b0);
    end
    apb(1, `TMR_OFF_MASK, 32'h2);
    for (int i = 0; i < 6; i++) begin
      m = cm[i / 2];
      p = i[0];
      s = (m == tmr_pkg::TMR_CMPCNT);
      far_u.drive(s, !p);
      apb(1, `TMR_OFF_STATUS, 32'h7);
      apb(1, `TMR_OFF_CTRL, ctl(m, p, 1'b1, 8'h00));
      far_u.drive(s, p);
      apb(0, `TMR_OFF_STATUS, 0);
      chk(rd[`TMR_ST_CAPTURE], 1'b0);
      far_u.drive(s, !p);
      apb(0, `TMR_OFF_STATUS, 0);
      chk(rd[`TMR_ST_CAPTURE], m != tmr_pkg::TMR_CAPCMP);
      far_u.drive(s, p);
      far_u.drive(s, !p);
      apb(0, `TMR_OFF_STATUS, 0);
      chk(rd[`TMR_ST_CAPTURE], 1'b1);
      chk(irq, 1'b1);
      apb(1, `TMR_OFF_CTRL, 32'h0);
      apb(1, `TMR_OFF_STATUS, 32'h7);
      tick(2);
      chk(irq, 1'b0);
    end
    apb(1, `TMR_OFF_RELOAD, 32'h20);
    apb(1, `TMR_OFF_PWM, 32'h08);
    for (int i = 0; i < 4; i++) begin
      p = i[0];
      d = i[1] ? 8'd3 : 8'd0;
      apb(1, `TMR_OFF_CTRL, ctl(tmr_pkg::TMR_PWM2, p, 1'b0, d));
      tick(2);
      chk({pin, pin_n, pin_oe}, {p, !p, 1'b1});
      apb(1, `TMR_OFF_CTRL, ctl(tmr_pkg::TMR_PWM2, p, 1'b1, d));
      high_width(w);
      chk(w, p ? 8 + d : 24 - d);
      chk(pin_n, p || d == 8'd0);
    end
    test_done();
  end
endmodule
`default_nettype wire
